//--- src/charger_option_pkg.sv
package charger_option_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint unsigned CLOCK_HZ = 250_000_000;
  localparam longint unsigned GLITCH_SHORT_US = 2;
  localparam longint unsigned GLITCH_MID_MS = 2;
  localparam longint unsigned GLITCH_LONG_S = 5;
  localparam longint unsigned DISCHARGE_MS = 40;
  localparam longint unsigned WAKE_MAX_MIN = 30;
  localparam longint unsigned WAKE_DEGLITCH_MIN = 1;
  localparam logic [31:0] GLITCH_SHORT_CYCLES =
    32'(GLITCH_SHORT_US * CLOCK_HZ / 1_000_000);
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OPT2_ADDR = 8'h38;
  localparam logic [7:0] OPT1_ADDR = 8'h3B;
  localparam logic [7:0] THR0_ADDR = 8'h3C;
  localparam logic [15:0] OPT1_RESET = 16'h0211;
  localparam logic [15:0] OPT1_MASK = 16'h1EFF;
  localparam logic [15:0] OPT2_RESET = 16'h0080;
  localparam logic [15:0] OPT2_MASK = 16'h00C0;
  localparam logic [15:0] THR0_RESET = 16'h4B54;
  localparam logic [15:0] THR0_MASK = 16'hFFFE;
  // option one fields
  localparam int RATIO_BIT = 12;
  localparam int BATMON_EN_BIT = 11;
  localparam int PWRMON_EN_BIT = 10;
  localparam int PWRMON_GAIN_BIT = 9;
  localparam int REF_SEL_BIT = 7;
  localparam int POLARITY_BIT = 6;
  localparam int GLITCH_SEL_LSB = 4;
  localparam int LATCH_EN_BIT = 3;
  localparam int FORCE_OFF_BIT = 2;
  localparam int DISCHARGE_BIT = 1;
  localparam int WAKE_EN_BIT = 0;
  // option two fields
  localparam int EXT_LIMIT_BIT = 7;
  localparam int BATMON_SEL_BIT = 6;
  // deglitch codes
  localparam logic [1:0] GLITCH_OFF = 2'h0;
  localparam logic [1:0] GLITCH_SHORT = 2'h1;
  localparam logic [1:0] GLITCH_MID = 2'h2;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic read;
    logic [15:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic sense_resistor_ratio;
    logic battery_current_monitor_en;
    logic system_power_monitor_en;
    logic power_monitor_gain;
    logic comparator_reference_select;
    logic external_limit_en;
    logic battery_monitor_charge;
  } analog_ctrl_t;
  typedef enum logic [1:0] {
    WAKE_IDLE = 2'b01,
    WAKE_CHARGE = 2'b10
  } wake_state_t;
endpackage

//--- src/charger_option_registers.sv
`timescale 1ns/1ps
module charger_option_registers #(
  parameter longint unsigned GLITCH_MID_CYCLES =
    charger_option_pkg::GLITCH_MID_MS * charger_option_pkg::CLOCK_HZ / 1000,
  parameter longint unsigned GLITCH_LONG_CYCLES =
    charger_option_pkg::GLITCH_LONG_S * charger_option_pkg::CLOCK_HZ,
  parameter longint unsigned DISCHARGE_CYCLES =
    charger_option_pkg::DISCHARGE_MS * charger_option_pkg::CLOCK_HZ / 1000,
  parameter longint unsigned WAKE_MAX_CYCLES =
    charger_option_pkg::WAKE_MAX_MIN * 60 * charger_option_pkg::CLOCK_HZ,
  parameter longint unsigned WAKE_DEGLITCH_CYCLES =
    charger_option_pkg::WAKE_DEGLITCH_MIN * 60 * charger_option_pkg::CLOCK_HZ
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // register access
  input wire charger_option_pkg::reg_req_t reg_req_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_ack_out,
  // analog status pins
  input wire logic comparator_input_in,
  input wire logic adapter_present_in,
  input wire logic battery_present_in,
  input wire logic battery_low_in,
  // analog controls
  output charger_option_pkg::analog_ctrl_t analog_ctrl_out,
  output logic comparator_output_out,
  output logic power_path_latch_off_out,
  output logic battery_switch_off_out,
  output logic battery_discharge_out,
  output logic wakeup_charge_out,
  output logic [15:0] throttle_options_out
);
  localparam logic [31:0] DEG_MID = 32'(GLITCH_MID_CYCLES);
  localparam logic [31:0] DEG_LONG = 32'(GLITCH_LONG_CYCLES);
  localparam logic [23:0] DISCH_LAST = 24'(DISCHARGE_CYCLES - 1);
  localparam logic [39:0] WAKE_LAST = 40'(WAKE_MAX_CYCLES - 1);
  localparam logic [39:0] WAKE_DEG_LAST = 40'(WAKE_DEGLITCH_CYCLES - 1);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] sync_a, sync_b;
  logic cmp_s, adapter_s, battery_s, low_s;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {battery_low_in, battery_present_in, adapter_present_in,
                 comparator_input_in};
      sync_b <= sync_a;
    end
  end

  assign cmp_s = sync_b[0];
  assign adapter_s = sync_b[1];
  assign battery_s = sync_b[2];
  assign low_s = sync_b[3];

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [15:0] opt1, opt2, thr0;
  logic [15:0] next_opt1, next_opt2, next_thr0;
  logic [15:0] rdata, next_rdata;
  logic ack, next_ack;
  logic adapter_prev;
  logic [23:0] disch_cnt, next_disch_cnt;
  logic wake_expire;
  logic wr1, wr2, wr3;

  assign wr1 = reg_req_in.write &&
               reg_req_in.addr == charger_option_pkg::OPT1_ADDR;
  assign wr2 = reg_req_in.write &&
               reg_req_in.addr == charger_option_pkg::OPT2_ADDR;
  assign wr3 = reg_req_in.write &&
               reg_req_in.addr == charger_option_pkg::THR0_ADDR;

  always_comb begin
    next_opt1 = opt1;
    next_opt2 = opt2;
    next_thr0 = thr0;
    next_rdata = rdata;
    next_ack = reg_req_in.read || reg_req_in.write;
    next_disch_cnt = 24'h000000;
    // pulldown ends on its own after the window
    if (opt1[charger_option_pkg::DISCHARGE_BIT]) begin
      if (disch_cnt == DISCH_LAST) begin
        next_opt1[charger_option_pkg::DISCHARGE_BIT] = 1'b0;
      end else begin
        next_disch_cnt = disch_cnt + 24'h000001;
      end
    end
    if (adapter_s && !adapter_prev) begin
      next_opt1[charger_option_pkg::FORCE_OFF_BIT] = 1'b0;
    end
    if (wake_expire) begin
      next_opt1[charger_option_pkg::WAKE_EN_BIT] = 1'b0;
    end
    // a host write lands last, so a write beats a same-cycle hardware clear
    if (wr1) begin
      next_opt1 = reg_req_in.wdata & charger_option_pkg::OPT1_MASK;
    end
    if (wr2) begin
      next_opt2 = reg_req_in.wdata & charger_option_pkg::OPT2_MASK;
    end
    if (wr3) begin
      next_thr0 = reg_req_in.wdata & charger_option_pkg::THR0_MASK;
    end
    if (reg_req_in.read) begin
      unique case (reg_req_in.addr)
        charger_option_pkg::OPT1_ADDR: next_rdata = opt1;
        charger_option_pkg::OPT2_ADDR: next_rdata = opt2;
        charger_option_pkg::THR0_ADDR: next_rdata = thr0;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      opt1 <= charger_option_pkg::OPT1_RESET;
      opt2 <= charger_option_pkg::OPT2_RESET;
      thr0 <= charger_option_pkg::THR0_RESET;
      rdata <= 16'h0000;
      ack <= 1'b0;
      adapter_prev <= 1'b0;
      disch_cnt <= 24'h000000;
    end else begin
      opt1 <= next_opt1;
      opt2 <= next_opt2;
      thr0 <= next_thr0;
      rdata <= next_rdata;
      ack <= next_ack;
      adapter_prev <= adapter_s;
      disch_cnt <= next_disch_cnt;
    end
  end

  // ----------------------------------------
  // independent comparator and latch-off
  // ----------------------------------------
  logic [1:0] deg_sel;
  logic [31:0] deg_last;
  logic [31:0] cmp_cnt, next_cmp_cnt;
  logic cmp_filt, next_cmp_filt;
  logic cmp_out, next_cmp_out;
  logic latch, next_latch;

  assign deg_sel = opt1[charger_option_pkg::GLITCH_SEL_LSB +: 2];

  always_comb begin
    unique case (deg_sel)
      charger_option_pkg::GLITCH_SHORT:
        deg_last = charger_option_pkg::GLITCH_SHORT_CYCLES - 32'h1;
      charger_option_pkg::GLITCH_MID: deg_last = DEG_MID - 32'h1;
      default: deg_last = DEG_LONG - 32'h1;
    endcase
  end

  always_comb begin
    next_cmp_cnt = 32'h0;
    next_cmp_filt = cmp_filt;
    next_latch = latch;
    if (deg_sel == charger_option_pkg::GLITCH_OFF) begin
      next_cmp_filt = 1'b0;
    end else if (cmp_s != cmp_filt) begin
      // a glitch shorter than the window restarts the count
      if (cmp_cnt >= deg_last) begin
        next_cmp_filt = cmp_s;
      end else begin
        next_cmp_cnt = cmp_cnt + 32'h1;
      end
    end
    next_cmp_out = opt1[charger_option_pkg::POLARITY_BIT] ?
                   next_cmp_filt : !next_cmp_filt;
    // besides nrst_in, losing both sources is the only thing that clears the latch
    if (!adapter_s && !battery_s) begin
      next_latch = 1'b0;
    end else if (cmp_filt && opt1[charger_option_pkg::LATCH_EN_BIT]) begin
      next_latch = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmp_cnt <= 32'h0;
      cmp_filt <= 1'b0;
      cmp_out <= 1'b1;
      latch <= 1'b0;
    end else begin
      cmp_cnt <= next_cmp_cnt;
      cmp_filt <= next_cmp_filt;
      cmp_out <= next_cmp_out;
      latch <= next_latch;
    end
  end

  // ----------------------------------------
  // automatic wake-up charge
  // ----------------------------------------
  charger_option_pkg::wake_state_t wake_state;
  charger_option_pkg::wake_state_t next_wake_state;
  logic [39:0] wake_cnt;
  logic [39:0] next_wake_cnt;
  logic [39:0] wake_deg_cnt;
  logic [39:0] next_wake_deg_cnt;

  always_comb begin
    next_wake_state = wake_state;
    next_wake_cnt = 40'h0;
    next_wake_deg_cnt = 40'h0;
    wake_expire = 1'b0;
    unique case (wake_state)
      charger_option_pkg::WAKE_IDLE: begin
        if (opt1[charger_option_pkg::WAKE_EN_BIT] && low_s) begin
          next_wake_state = charger_option_pkg::WAKE_CHARGE;
        end
      end
      charger_option_pkg::WAKE_CHARGE: begin
        next_wake_cnt = wake_cnt + 40'h1;
        if (!opt1[charger_option_pkg::WAKE_EN_BIT]) begin
          next_wake_state = charger_option_pkg::WAKE_IDLE;
        end else if (wake_cnt == WAKE_LAST) begin
          wake_expire = 1'b1;
          next_wake_state = charger_option_pkg::WAKE_IDLE;
        end else if (!low_s) begin
          next_wake_deg_cnt = wake_deg_cnt + 40'h1;
          if (wake_deg_cnt == WAKE_DEG_LAST) begin
            next_wake_state = charger_option_pkg::WAKE_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wake_state <= charger_option_pkg::WAKE_IDLE;
      wake_cnt <= 40'h0;
      wake_deg_cnt <= 40'h0;
    end else begin
      wake_state <= next_wake_state;
      wake_cnt <= next_wake_cnt;
      wake_deg_cnt <= next_wake_deg_cnt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata_out = rdata;
  assign reg_ack_out = ack;
  assign analog_ctrl_out.sense_resistor_ratio =
    opt1[charger_option_pkg::RATIO_BIT];
  assign analog_ctrl_out.battery_current_monitor_en =
    opt1[charger_option_pkg::BATMON_EN_BIT];
  assign analog_ctrl_out.system_power_monitor_en =
    opt1[charger_option_pkg::PWRMON_EN_BIT];
  assign analog_ctrl_out.power_monitor_gain =
    opt1[charger_option_pkg::PWRMON_GAIN_BIT];
  assign analog_ctrl_out.comparator_reference_select =
    opt1[charger_option_pkg::REF_SEL_BIT];
  assign analog_ctrl_out.external_limit_en =
    opt2[charger_option_pkg::EXT_LIMIT_BIT];
  assign analog_ctrl_out.battery_monitor_charge =
    opt2[charger_option_pkg::BATMON_SEL_BIT];
  assign comparator_output_out = cmp_out;
  assign power_path_latch_off_out = latch;
  assign battery_switch_off_out = opt1[charger_option_pkg::FORCE_OFF_BIT];
  assign battery_discharge_out = opt1[charger_option_pkg::DISCHARGE_BIT];
  assign wakeup_charge_out = wake_state == charger_option_pkg::WAKE_CHARGE;
  assign throttle_options_out = thr0;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  a_ratio_write: assert property (wr1 |=>
    analog_ctrl_out.sense_resistor_ratio == $past(reg_req_in.wdata[12]))
    else $error("ratio bit not taken from write");
  a_batmon_write: assert property (wr1 |=>
    analog_ctrl_out.battery_current_monitor_en ==
    $past(reg_req_in.wdata[11]))
    else $error("battery monitor enable not taken");
  a_pwrmon_write: assert property (wr1 |=>
    analog_ctrl_out.system_power_monitor_en == $past(reg_req_in.wdata[10])
    && analog_ctrl_out.power_monitor_gain == $past(reg_req_in.wdata[9]))
    else $error("power monitor bits not taken");
  a_ref_select: assert property (wr1 |=>
    analog_ctrl_out.comparator_reference_select ==
    $past(reg_req_in.wdata[7]))
    else $error("comparator reference not taken");
  a_cmp_polarity: assert property (
    $past(opt1[6]) == opt1[6] |->
    comparator_output_out == (opt1[6] ? cmp_filt : !cmp_filt))
    else $error("comparator output polarity wrong");
  a_cmp_disabled: assert property (deg_sel == 2'h0 |=> !cmp_filt)
    else $error("disabled comparator still triggered");
  a_cmp_short_deg: assert property (
    deg_sel == 2'h1 && !cmp_filt && cmp_s [*8] |-> ##[0:500] cmp_filt)
    else $error("short deglitch too long");
  a_latch_hold: assert property (
    latch && (adapter_s || battery_s) |=> latch)
    else $error("latch-off released while powered");
  a_force_clear: assert property (
    adapter_s && !adapter_prev && !wr1 |=> !battery_switch_off_out)
    else $error("force-off not cleared on adapter");
  a_disch_end: assert property (
    battery_discharge_out && disch_cnt == DISCH_LAST && !wr1
    |=> !battery_discharge_out)
    else $error("discharge did not end");
  a_wake_start: assert property (
    wake_state == charger_option_pkg::WAKE_IDLE && low_s && opt1[0]
    |=> wakeup_charge_out)
    else $error("wake-up charge not started");
  a_wake_expire: assert property (wake_expire && !wr1 |=>
    !opt1[0] && !wakeup_charge_out)
    else $error("expiry did not clear enable");
  a_limit_write: assert property (wr2 |=>
    analog_ctrl_out.external_limit_en == $past(reg_req_in.wdata[7]) &&
    analog_ctrl_out.battery_monitor_charge == $past(reg_req_in.wdata[6]))
    else $error("option two bits not taken");
  a_reserved_zero: assert property (
    reg_req_in.read && reg_req_in.addr == 8'h3B |=>
    (reg_rdata_out & 16'hE100) == 16'h0000 && reg_ack_out)
    else $error("reserved bits read nonzero");
endmodule

//--- testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clock_in,
  // answer from the option registers
  input wire logic reg_ack_in,
  input wire logic [15:0] reg_rdata_in,
  // request to the option registers
  output charger_option_pkg::reg_req_t reg_req_out
);
  // ----------------------------------------
  // single access
  // ----------------------------------------
  logic [15:0] last_rdata;
  initial reg_req_out = '0;
  // strobe stands for one taking edge only; the answer is seen a cycle later
  task automatic access(input logic wr, input logic [7:0] addr,
                        input logic [15:0] wdata, output logic ok);
    @(negedge clock_in);
    reg_req_out.addr = addr;
    reg_req_out.write = wr;
    reg_req_out.read = !wr;
    reg_req_out.wdata = wdata;
    @(negedge clock_in);
    reg_req_out = '0;
    ok = reg_ack_in;
    last_rdata = reg_rdata_in;
  endtask
endmodule

//--- testbench/tb_charger_option_registers.sv
`timescale 1ns/1ps
module tb_charger_option_registers;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic cmp_in = 1'b0;
  logic adapter = 1'b0;
  logic battery = 1'b1;
  logic low = 1'b0;
  charger_option_pkg::reg_req_t req;
  charger_option_pkg::analog_ctrl_t ctrl;
  logic [15:0] rdata;
  logic [15:0] thr;
  logic ack, cmp_out, latch, sw_off, dis, wake, ok;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  int win[3] = '{500, 20, 40};
  always #2 clock_in = ~clock_in;
  // ----------------------------------------
  // design and host
  // ----------------------------------------
  // short counts keep the run small; expectations below follow them
  charger_option_registers #(.GLITCH_MID_CYCLES(20),
    .GLITCH_LONG_CYCLES(40), .DISCHARGE_CYCLES(16),
    .WAKE_MAX_CYCLES(200), .WAKE_DEGLITCH_CYCLES(30)) uut (
    .clock_in(clock_in), .nrst_in(nrst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_ack_out(ack),
    .comparator_input_in(cmp_in), .adapter_present_in(adapter),
    .battery_present_in(battery), .battery_low_in(low),
    .analog_ctrl_out(ctrl), .comparator_output_out(cmp_out),
    .power_path_latch_off_out(latch), .battery_switch_off_out(sw_off),
    .battery_discharge_out(dis), .wakeup_charge_out(wake),
    .throttle_options_out(thr));
  host_model host (.clock_in(clock_in), .reg_ack_in(ack),
    .reg_rdata_in(rdata), .reg_req_out(req));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
                          input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.access(1'b1, a, d, ok);
    chk_bit(ok, 1'b1, "write ack");
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    host.access(1'b0, a, 16'h0000, ok);
    chk_bit(ok, 1'b1, "read ack");
    chk_word(host.last_rdata, exp, "read data");
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, far above the few thousand cycles the tests need
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("MISMATCH t=%0t run did not finish", $time);
      wrap_up();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    idle(12);
    nrst_in = 1'b1;
    idle(2);
    rd(8'h3B, 16'h0211);
    rd(8'h38, 16'h0080);
    rd(8'h3C, 16'h4B54);
    chk_word({9'h000, ctrl}, 16'h000A, "ctrl reset");
    chk_bit(cmp_out, 1'b1, "cmp reset");
    chk_bit(latch, 1'b0, "latch reset");
    chk_bit(wake, 1'b0, "wake reset");
    // reserved bits and field outputs
    wr(8'h3B, 16'hFFFF);
    rd(8'h3B, 16'h1EFF);
    chk_word({9'h000, ctrl}, 16'h007E, "ctrl opt1 set");
    wr(8'h3B, 16'h0000);
    rd(8'h3B, 16'h0000);
    chk_word({9'h000, ctrl}, 16'h0002, "ctrl opt1 clear");
    chk_bit(dis, 1'b0, "discharge stopped");
    wr(8'h38, 16'hFFFF);
    rd(8'h38, 16'h00C0);
    chk_word({9'h000, ctrl}, 16'h0003, "ctrl opt2 set");
    wr(8'h38, 16'h0000);
    chk_word({9'h000, ctrl}, 16'h0000, "ctrl opt2 clear");
    wr(8'h40, 16'h1234);
    rd(8'h40, 16'h0000);
    wr(8'h3C, 16'hFFFF);
    rd(8'h3C, 16'hFFFE);
    chk_word(thr, 16'hFFFE, "throttle out");
    // comparator off: output is inverse of polarity
    cmp_in = 1'b1;
    wr(8'h3B, 16'h0040);
    idle(3);
    chk_bit(cmp_out, 1'b0, "cmp off pol1");
    wr(8'h3B, 16'h0000);
    idle(3);
    chk_bit(cmp_out, 1'b1, "cmp off pol0");
    cmp_in = 1'b0;
    for (int i = 0; i < 3; i++) begin
      wr(8'h3B, 16'h0040 | (16'(i + 1) << 4));
      idle(3);
      chk_bit(cmp_out, 1'b0, "cmp idle");
      cmp_in = 1'b1;
      idle(win[i] - 4);
      chk_bit(cmp_out, 1'b0, "cmp in deglitch");
      idle(12);
      chk_bit(cmp_out, 1'b1, "cmp high");
      cmp_in = 1'b0;
      idle(win[i] + 12);
    end
    // force-off cleared by adapter plug-in
    wr(8'h3B, 16'h0014);
    idle(2);
    chk_bit(sw_off, 1'b1, "force off");
    adapter = 1'b1;
    idle(6);
    chk_bit(sw_off, 1'b0, "force off cleared");
    rd(8'h3B, 16'h0010);
    // timed discharge clears itself
    wr(8'h3B, 16'h0012);
    idle(2);
    chk_bit(dis, 1'b1, "discharge on");
    idle(20);
    chk_bit(dis, 1'b0, "discharge over");
    rd(8'h3B, 16'h0010);
    // latch-off holds until both sources are gone
    wr(8'h3B, 16'h0018);
    cmp_in = 1'b1;
    idle(510);
    chk_bit(cmp_out, 1'b0, "cmp pol0 trip");
    chk_bit(latch, 1'b1, "latch set");
    cmp_in = 1'b0;
    adapter = 1'b0;
    idle(600);
    chk_bit(latch, 1'b1, "latch held");
    battery = 1'b0;
    idle(5);
    chk_bit(latch, 1'b0, "latch cleared");
    battery = 1'b1;
    adapter = 1'b1;
    // wake-up charge: deglitched stop, then expiry
    wr(8'h3B, 16'h0011);
    low = 1'b1;
    idle(5);
    chk_bit(wake, 1'b1, "wake start");
    low = 1'b0;
    idle(20);
    chk_bit(wake, 1'b1, "wake in deglitch");
    idle(20);
    chk_bit(wake, 1'b0, "wake stop");
    rd(8'h3B, 16'h0011);
    low = 1'b1;
    idle(5);
    chk_bit(wake, 1'b1, "wake restart");
    idle(150);
    chk_bit(wake, 1'b1, "wake running");
    idle(60);
    chk_bit(wake, 1'b0, "wake expired");
    rd(8'h3B, 16'h0010);
    low = 1'b0;
    wrap_up();
  end
endmodule
